// [shared/dprc_pkg.sv]
package dprc_pkg;

    // ----------------------------------------
    // array geometry
    // ----------------------------------------
    localparam int unsigned ADDR_W = 9;
    localparam int unsigned DATA_W = 16;
    localparam int unsigned BYTE_W = 8;
    localparam int unsigned BE_W   = DATA_W / BYTE_W;
    localparam int unsigned DEPTH  = 1 << ADDR_W;

    // ----------------------------------------
    // register map (byte addresses)
    // ----------------------------------------
    localparam int unsigned    WB_AW    = 4;
    localparam int unsigned    WB_DW    = 32;
    localparam logic [3:0]     REG_CTRL = 4'h0;
    localparam logic [3:0]     REG_STAT = 4'h4;
    localparam int unsigned    CTRL_W   = 16;
    localparam logic [15:0]    CTRL_RST = 16'h0232;
    localparam logic [15:0]    CTRL_MSK = 16'h3337;
    localparam int unsigned    MODE_LSB = 0;
    localparam int unsigned    CLK_LSB  = 4;
    localparam int unsigned    SPNEW_B  = 8;
    localparam int unsigned    MIXOLD_B = 9;
    localparam int unsigned    OREGA_B  = 12;
    localparam int unsigned    OREGB_B  = 13;
    localparam int unsigned    STAT_BAD = 0;
    localparam int unsigned    STAT_UND = 1;
    localparam int unsigned    STAT_COL = 2;

    // ----------------------------------------
    // modes and clocking schemes
    // ----------------------------------------
    typedef enum logic [2:0] {
        MODE_SP   = 3'b000,
        MODE_SDP  = 3'b001,
        MODE_TDP  = 3'b010,
        MODE_ROM  = 3'b011,
        MODE_FIFO = 3'b100
    } dprc_mode_t;

    typedef enum logic [1:0] {
        CLK_INDEP  = 2'b00,
        CLK_IO     = 2'b01,
        CLK_RW     = 2'b10,
        CLK_SINGLE = 2'b11
    } dprc_clk_t;

    // ----------------------------------------
    // one port request from the fabric
    // ----------------------------------------
    typedef struct packed {
        logic [ADDR_W-1:0] addr;
        logic [DATA_W-1:0] wdata;
        logic              we;
        logic              re;
        logic [BE_W-1:0]   be;
    } dprc_req_t;

endpackage : dprc_pkg

// [rtl/dprc_ram.sv]
// Local design decisions: register access over Wishbone and the address map.
`timescale 1ns/1ps

// Functional notes
// - read/write scheme same-address collision gives undefined read
// - async clear only read address, outputs, latches
// - each clocking scheme allowed only for listed modes
// - independent scheme: each port on its own clock
// - independent scheme: per-port enable gates own port
// - io scheme: input clock inputs, output clock outputs
// - io scheme: separate input and output enables
// - rw scheme: write clock writes, read clock reads
// - rw scheme: independent read and write enables
// - single scheme: one clock plus one enable
// - flow-through shows written data same cycle
// - old-data mode shows contents before write
// - masked bytes keep old data, show old data
// - mixed-port: old data if configured, else undefined
// - mixed-port on differing clocks is undefined
// - read outputs cleared at power-up
// - array preloaded; first read returns preload
// - clock enables suspend the block
// - output register adds one cycle latency
module dprc_ram #(
    parameter logic [dprc_pkg::DATA_W-1:0] INIT_FILL  = 16'h0000,
    parameter logic [dprc_pkg::DATA_W-1:0] UNDEF_FILL = 16'hFFFF
) (
    // clock and reset
    input  wire logic                        ref_clk_in,
    input  wire logic                        resetn_in,
    // wishbone slave
    input  wire logic                        wb_cyc_in,
    input  wire logic                        wb_stb_in,
    input  wire logic                        wb_we_in,
    input  wire logic [dprc_pkg::WB_AW-1:0]  wb_adr_in,
    input  wire logic [dprc_pkg::WB_DW-1:0]  wb_dat_in,
    input  wire logic [3:0]                  wb_sel_in,
    output logic      [dprc_pkg::WB_DW-1:0]  wb_dat_out,
    output logic                             wb_ack_out,
    // port a
    input  wire dprc_pkg::dprc_req_t         port_a_in,
    input  wire logic                        a_in_ce_in,
    input  wire logic                        a_out_ce_in,
    output logic      [dprc_pkg::DATA_W-1:0] q_a_out,
    // port b
    input  wire dprc_pkg::dprc_req_t         port_b_in,
    input  wire logic                        b_in_ce_in,
    input  wire logic                        b_out_ce_in,
    output logic      [dprc_pkg::DATA_W-1:0] q_b_out
);

    localparam int DW   = dprc_pkg::DATA_W;
    localparam int BW   = dprc_pkg::BYTE_W;
    localparam int BEW  = dprc_pkg::BE_W;
    localparam int AW   = dprc_pkg::ADDR_W;

    // ----------------------------------------
    // storage and pipeline state
    // ----------------------------------------
    logic [DW-1:0]        mem [dprc_pkg::DEPTH];
    dprc_pkg::dprc_req_t  req [2];
    dprc_pkg::dprc_req_t  req_q [2] = '{default: '0};
    logic [AW-1:0]        raddr_q [2];
    logic [1:0]           act = 2'h0;
    logic [DW-1:0]        lat [2];
    logic [DW-1:0]        rd_old [2];
    logic [DW-1:0]        merged [2];
    logic [DW-1:0]        next_lat [2];
    logic [1:0]           in_ce;
    logic [1:0]           out_ce;
    logic [1:0]           wr;
    logic [1:0]           rd;
    logic [1:0]           wr_ok;
    logic [1:0]           rd_ok;
    logic [1:0]           mixed;
    logic [1:0]           undef;
    logic [1:0]           oreg;
    logic                 same_clk;
    logic                 cfg_ok;
    logic                 coll_ev;
    logic [dprc_pkg::CTRL_W-1:0] ctrl;
    dprc_pkg::dprc_mode_t mode;
    dprc_pkg::dprc_clk_t  scheme;
    logic                 sp_new;
    logic                 mix_old;
    logic                 stat_und;
    logic                 stat_col;
    logic                 wb_req;
    logic                 wb_wr;
    logic                 stat_clr;

    assign req[0]  = port_a_in;
    assign req[1]  = port_b_in;
    assign mode    = dprc_pkg::dprc_mode_t'(ctrl[dprc_pkg::MODE_LSB +: 3]);
    assign scheme  = dprc_pkg::dprc_clk_t'(ctrl[dprc_pkg::CLK_LSB +: 2]);
    assign sp_new  = ctrl[dprc_pkg::SPNEW_B];
    assign mix_old = ctrl[dprc_pkg::MIXOLD_B];
    assign oreg    = {ctrl[dprc_pkg::OREGB_B], ctrl[dprc_pkg::OREGA_B]};

    // ----------------------------------------
    // preload
    // ----------------------------------------
    // contents come up from a fixed pattern, not a file, so no reset touches the array
    initial begin
        for (int i = 0; i < int'(dprc_pkg::DEPTH); i++) begin
            mem[i] = INIT_FILL ^ DW'(i);
        end
    end

    // ----------------------------------------
    // scheme legality and clock enable routing
    // ----------------------------------------
    always_comb begin
        case (scheme)
            dprc_pkg::CLK_INDEP: begin
                cfg_ok = (mode == dprc_pkg::MODE_TDP) || (mode == dprc_pkg::MODE_ROM);
            end
            dprc_pkg::CLK_IO: begin
                cfg_ok = (mode == dprc_pkg::MODE_TDP) || (mode == dprc_pkg::MODE_SDP)
                      || (mode == dprc_pkg::MODE_SP) || (mode == dprc_pkg::MODE_ROM);
            end
            dprc_pkg::CLK_RW: begin
                cfg_ok = (mode == dprc_pkg::MODE_SDP) || (mode == dprc_pkg::MODE_FIFO);
            end
            dprc_pkg::CLK_SINGLE: begin
                cfg_ok = mode <= dprc_pkg::MODE_FIFO;
            end
            default: begin
                cfg_ok = 1'b0;
            end
        endcase
    end

    always_comb begin
        case (scheme)
            dprc_pkg::CLK_INDEP: begin
                in_ce  = {b_in_ce_in, a_in_ce_in};
                out_ce = {b_in_ce_in, a_in_ce_in};
            end
            dprc_pkg::CLK_IO: begin
                in_ce  = {b_in_ce_in, a_in_ce_in};
                out_ce = {b_out_ce_in, a_out_ce_in};
            end
            dprc_pkg::CLK_RW: begin
                in_ce  = {b_in_ce_in, a_in_ce_in};
                out_ce = {b_in_ce_in, a_in_ce_in};
            end
            dprc_pkg::CLK_SINGLE: begin
                in_ce  = {a_in_ce_in, a_in_ce_in};
                out_ce = {a_in_ce_in, a_in_ce_in};
            end
            default: begin
                in_ce  = 2'h0;
                out_ce = 2'h0;
            end
        endcase
    end

    // only io and single share one edge for both ports; the rest may race
    assign same_clk = (scheme == dprc_pkg::CLK_IO) || (scheme == dprc_pkg::CLK_SINGLE);
    assign wr_ok[0] = cfg_ok && (mode != dprc_pkg::MODE_ROM);
    assign wr_ok[1] = cfg_ok && (mode == dprc_pkg::MODE_TDP);
    assign rd_ok[0] = cfg_ok && (mode != dprc_pkg::MODE_SDP) && (mode != dprc_pkg::MODE_FIFO);
    assign rd_ok[1] = cfg_ok && (mode != dprc_pkg::MODE_SP);

    // ----------------------------------------
    // input registers
    // ----------------------------------------
    // write side registers carry no clear; the read address alone does
    always_ff @(posedge ref_clk_in) begin
        for (int p = 0; p < 2; p++) begin
            act[p] <= in_ce[p];
            if (in_ce[p]) begin
                req_q[p] <= req[p];
            end
        end
    end

    always_ff @(posedge ref_clk_in or negedge resetn_in) begin
        if (!resetn_in) begin
            raddr_q[0] <= '0;
            raddr_q[1] <= '0;
        end else begin
            for (int p = 0; p < 2; p++) begin
                if (in_ce[p]) begin
                    raddr_q[p] <= req[p].addr;
                end
            end
        end
    end

    // ----------------------------------------
    // array access
    // ----------------------------------------
    // a low read enable only leaves the latch untouched; the array is still read combinationally through rd_old
    assign wr = act & {req_q[1].we, req_q[0].we} & wr_ok;
    assign rd = act & {req_q[1].re, req_q[0].re} & rd_ok;
    assign rd_old[0] = mem[raddr_q[0]];
    assign rd_old[1] = mem[raddr_q[1]];
    assign coll_ev = wr[0] && wr[1] && (req_q[0].addr == req_q[1].addr);

    // port b is written first so port a wins a collision; no arbitration beyond that
    // plain always: the preload above also writes this array
    always @(posedge ref_clk_in) begin
        for (int p = 1; p >= 0; p--) begin
            if (wr[p]) begin
                for (int k = 0; k < BEW; k++) begin
                    if (req_q[p].be[k]) begin
                        mem[req_q[p].addr][k*BW +: BW] <= req_q[p].wdata[k*BW +: BW];
                    end
                end
            end
        end
    end

    // ----------------------------------------
    // read-during-write selection
    // ----------------------------------------
    always_comb begin
        for (int p = 0; p < 2; p++) begin
            merged[p] = rd_old[p];
            for (int k = 0; k < BEW; k++) begin
                if (req_q[p].be[k]) begin
                    merged[p][k*BW +: BW] = req_q[p].wdata[k*BW +: BW];
                end
            end
            mixed[p] = rd[p] && wr[1-p] && !wr[p] && (raddr_q[p] == req_q[1-p].addr);
            undef[p] = mixed[p] && !(same_clk && mix_old);
            if (undef[p]) begin
                next_lat[p] = UNDEF_FILL;
            end else if (wr[p] && sp_new) begin
                next_lat[p] = merged[p];
            end else begin
                next_lat[p] = rd_old[p];
            end
        end
    end

    // ----------------------------------------
    // output latches and registers
    // ----------------------------------------
    always_ff @(posedge ref_clk_in or negedge resetn_in) begin
        if (!resetn_in) begin
            lat[0] <= '0;
            lat[1] <= '0;
        end else begin
            for (int p = 0; p < 2; p++) begin
                if (rd[p]) begin
                    lat[p] <= next_lat[p];
                end
            end
        end
    end

    always_ff @(posedge ref_clk_in or negedge resetn_in) begin
        if (!resetn_in) begin
            q_a_out <= '0;
        end else if (oreg[0]) begin
            if (out_ce[0]) begin
                q_a_out <= lat[0];
            end
        end else if (rd[0]) begin
            q_a_out <= next_lat[0];
        end
    end

    always_ff @(posedge ref_clk_in or negedge resetn_in) begin
        if (!resetn_in) begin
            q_b_out <= '0;
        end else if (oreg[1]) begin
            if (out_ce[1]) begin
                q_b_out <= lat[1];
            end
        end else if (rd[1]) begin
            q_b_out <= next_lat[1];
        end
    end

    // ----------------------------------------
    // wishbone slave
    // ----------------------------------------
    assign wb_req   = wb_cyc_in && wb_stb_in && !wb_ack_out;
    assign wb_wr    = wb_req && wb_we_in;
    assign stat_clr = wb_wr && (wb_adr_in == dprc_pkg::REG_STAT) && wb_sel_in[0];

    always_ff @(posedge ref_clk_in or negedge resetn_in) begin
        if (!resetn_in) begin
            wb_ack_out <= 1'b0;
        end else begin
            wb_ack_out <= wb_req;
        end
    end

    always_ff @(posedge ref_clk_in or negedge resetn_in) begin
        if (!resetn_in) begin
            ctrl <= dprc_pkg::CTRL_RST;
        end else if (wb_wr && (wb_adr_in == dprc_pkg::REG_CTRL)) begin
            for (int b = 0; b < 2; b++) begin
                if (wb_sel_in[b]) begin
                    ctrl[b*8 +: 8] <= wb_dat_in[b*8 +: 8] & dprc_pkg::CTRL_MSK[b*8 +: 8];
                end
            end
        end
    end

    // a new event outweighs a clear in the same cycle
    always_ff @(posedge ref_clk_in or negedge resetn_in) begin
        if (!resetn_in) begin
            stat_und <= 1'b0;
            stat_col <= 1'b0;
        end else begin
            if (|undef) begin
                stat_und <= 1'b1;
            end else if (stat_clr && wb_dat_in[dprc_pkg::STAT_UND]) begin
                stat_und <= 1'b0;
            end
            if (coll_ev) begin
                stat_col <= 1'b1;
            end else if (stat_clr && wb_dat_in[dprc_pkg::STAT_COL]) begin
                stat_col <= 1'b0;
            end
        end
    end

    always_ff @(posedge ref_clk_in or negedge resetn_in) begin
        if (!resetn_in) begin
            wb_dat_out <= '0;
        end else if (wb_req && !wb_we_in) begin
            case (wb_adr_in)
                dprc_pkg::REG_CTRL: begin
                    wb_dat_out <= {16'h0000, ctrl};
                end
                dprc_pkg::REG_STAT: begin
                    wb_dat_out <= {29'h00000000, stat_col, stat_und, !cfg_ok};
                end
                default: begin
                    wb_dat_out <= '0;
                end
            endcase
        end
    end

    // ----------------------------------------
    // checks
    // ----------------------------------------
    default clocking dprc_cb @(posedge ref_clk_in); endclocking
    default disable iff (!resetn_in);

    hold_in_a: assert property (!in_ce[0] |=> $stable(raddr_q[0]) && $stable(req_q[0]))
        else $error("port a input registers moved while disabled");
    b_rd_hold_a: assert property (!rd[1] && !oreg[1] && !$changed(ctrl) |=> $stable(q_b_out))
        else $error("port b output moved without a read");
    oreg_delay_a: assert property (oreg[0] && out_ce[0] |=> q_a_out == $past(lat[0]))
        else $error("registered output did not follow latch");
    flow_thru_a: assert property (rd[0] && wr[0] && sp_new && req_q[0].be[0]
                                  |=> lat[0][BW-1:0] == $past(req_q[0].wdata[BW-1:0]))
        else $error("flow-through data missing");
    old_data_a: assert property (rd[0] && wr[0] && !sp_new |=> lat[0] == $past(rd_old[0]))
        else $error("old data not returned");
    byte_mask_a: assert property (rd[0] && wr[0] && sp_new && !req_q[0].be[1]
                                  |=> lat[0][DW-1:BW] == $past(rd_old[0][DW-1:BW]))
        else $error("masked bytes not old data");
    mixed_old_a: assert property (mixed[1] && same_clk && mix_old |=> lat[1] == $past(rd_old[1]))
        else $error("mixed port old data wrong");
    rw_undef_a: assert property (mixed[1] && scheme == dprc_pkg::CLK_RW
                                 |=> lat[1] == UNDEF_FILL && stat_und)
        else $error("rw collision not flagged undefined");
    pwr_clear_a: assert property (@(posedge ref_clk_in) disable iff (1'b0)
                                  !resetn_in |-> q_a_out == '0 && q_b_out == '0)
        else $error("outputs not cleared in reset");
    cfg_gate_a: assert property (!cfg_ok |=> $stable(lat[0]) && $stable(lat[1]))
        else $error("illegal scheme still accessed");
    single_ce_a: assert property (scheme == dprc_pkg::CLK_SINGLE && !a_in_ce_in
                                  |=> $stable(raddr_q[1]))
        else $error("single clock enable ignored");
    io_out_a: assert property (scheme == dprc_pkg::CLK_IO && oreg[0] && !a_out_ce_in
                               |=> $stable(q_a_out))
        else $error("io output enable ignored");
    rw_rclk_a: assert property (scheme == dprc_pkg::CLK_RW && !b_in_ce_in
                                |=> $stable(raddr_q[1]))
        else $error("read clock enable ignored");

endmodule : dprc_ram

// [tb/dprc_fabric_model.sv]
`timescale 1ns/1ps

// ----------------------------------------
// fabric side request driver
// ----------------------------------------
module dprc_fabric_model (
    // requests from the bench
    input  wire dprc_pkg::dprc_req_t a_cmd_in,
    input  wire dprc_pkg::dprc_req_t b_cmd_in,
    // requests to the ram ports
    output dprc_pkg::dprc_req_t      port_a_out,
    output dprc_pkg::dprc_req_t      port_b_out
);
    assign port_a_out = a_cmd_in;

    // the ram arbitrates only by write order, with port a winning, and the fabric drops b's write on an address clash
    always_comb begin
        port_b_out = b_cmd_in;
        if (a_cmd_in.we && b_cmd_in.we && (a_cmd_in.addr == b_cmd_in.addr)) begin
            port_b_out.we = 1'b0;
        end
    end
endmodule : dprc_fabric_model

// [tb/dprc_ram_tb_top.sv]
`timescale 1ns/1ps

module dprc_ram_tb_top;

    // ----------------------------------------
    // bench signals
    // ----------------------------------------
    logic                        ref_clk_in = 1'b0;
    logic                        resetn_in;
    logic                        wb_cyc     = 1'b0;
    logic                        wb_stb     = 1'b0;
    logic                        wb_we      = 1'b0;
    logic [3:0]                  wb_adr     = 4'h0;
    logic [31:0]                 wb_dat     = 32'h0;
    logic [3:0]                  wb_sel     = 4'h0;
    logic [31:0]                 wb_rdat;
    logic                        wb_ack;
    logic [3:0]                  ce         = 4'hF;
    dprc_pkg::dprc_req_t         a_cmd      = '0;
    dprc_pkg::dprc_req_t         b_cmd      = '0;
    dprc_pkg::dprc_req_t         port_a;
    dprc_pkg::dprc_req_t         port_b;
    logic [15:0]                 q_a;
    logic [15:0]                 q_b;
    logic [15:0]                 ref_mem [dprc_pkg::DEPTH];
    logic [31:0]                 rd;
    integer                      seed       = 32'hB557C9A3;
    int                          fail_count = 0;
    int                          checked    = 0;

    initial begin
        forever #50 ref_clk_in = ~ref_clk_in;
    end

    dprc_fabric_model dprc_fabric_model_i (.a_cmd_in(a_cmd), .b_cmd_in(b_cmd),
                                           .port_a_out(port_a), .port_b_out(port_b));

    dprc_ram dprc_ram_i (.ref_clk_in(ref_clk_in), .resetn_in(resetn_in), .wb_cyc_in(wb_cyc),
        .wb_stb_in(wb_stb), .wb_we_in(wb_we), .wb_adr_in(wb_adr), .wb_dat_in(wb_dat), .wb_sel_in(wb_sel),
        .wb_dat_out(wb_rdat), .wb_ack_out(wb_ack), .port_a_in(port_a), .a_in_ce_in(ce[0]),
        .a_out_ce_in(ce[1]), .q_a_out(q_a), .port_b_in(port_b), .b_in_ce_in(ce[2]),
        .b_out_ce_in(ce[3]), .q_b_out(q_b));

    // ----------------------------------------
    // tasks and expectation helpers
    // ----------------------------------------
    task automatic complete_run;
        if (fail_count == 0 && checked > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask : complete_run

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        checked++;
        if (seen !== exp) begin
            fail_count++;
            $display("MISMATCH at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask : check

    // classic cycle, held until ack is sampled high
    task automatic wb(input logic we, input logic [3:0] adr, input logic [31:0] dat);
        int n;
        @(posedge ref_clk_in);
        wb_cyc <= 1'b1;
        wb_stb <= 1'b1;
        wb_we  <= we;
        wb_adr <= adr;
        wb_dat <= dat;
        wb_sel <= 4'hF;
        for (n = 0; n < 20; n++) begin
            @(posedge ref_clk_in);
            if (wb_ack === 1'b1) break;
        end
        rd = wb_rdat;
        wb_cyc <= 1'b0;
        wb_stb <= 1'b0;
        if (n == 20) begin
            fail_count++;
            complete_run();
        end
    endtask : wb

    function automatic dprc_pkg::dprc_req_t mk(input logic [8:0] ad, input logic [15:0] wd,
                                               input logic w, input logic r, input logic [1:0] be);
        mk = '{addr: ad, wdata: wd, we: w, re: r, be: be};
    endfunction : mk

    // idle keeps read and write enables low, other lines scrambled
    function automatic dprc_pkg::dprc_req_t idle();
        idle = mk(9'($random(seed)), 16'($random(seed)), 1'b0, 1'b0, 2'($random(seed)));
    endfunction : idle

    function automatic logic [15:0] merge(input logic [15:0] o, input logic [15:0] n, input logic [1:0] be);
        merge = {be[1] ? n[15:8] : o[15:8], be[0] ? n[7:0] : o[7:0]};
    endfunction : merge

    // request on one edge, idle on the next, return once the read has landed
    task automatic op(input dprc_pkg::dprc_req_t a, input dprc_pkg::dprc_req_t b);
        @(posedge ref_clk_in);
        a_cmd <= a;
        b_cmd <= b;
        @(posedge ref_clk_in);
        a_cmd <= idle();
        b_cmd <= idle();
        @(posedge ref_clk_in);
        #1;
    endtask : op

    // ----------------------------------------
    // scenarios
    // ----------------------------------------
    initial begin
        logic [8:0]  ad;
        logic [15:0] wd;
        logic [1:0]  be;
        logic        w;
        // a real falling edge at time zero, so the asynchronous clear takes hold
        resetn_in <= 1'b0;
        for (int i = 0; i < dprc_pkg::DEPTH; i++) ref_mem[i] = 16'(i);
        repeat (10) @(posedge ref_clk_in);
        resetn_in <= 1'b1;
        check(32'(q_a), 32'h0);
        check(32'(q_b), 32'h0);
        wb(1'b0, dprc_pkg::REG_CTRL, 32'h0);
        check(rd, 32'h0232);
        wb(1'b0, 4'h8, 32'h0);
        check(rd, 32'h0);
        op(mk(9'h1A5, 16'h0, 1'b0, 1'b1, 2'b00), mk(9'h003, 16'h0, 1'b0, 1'b1, 2'b00));
        check(32'(q_a), 32'(ref_mem[9'h1A5]));
        check(32'(q_b), 32'(ref_mem[3]));
        wb(1'b1, dprc_pkg::REG_CTRL, 32'h0332);
        op(mk(9'h005, 16'hABCD, 1'b1, 1'b1, 2'b01), idle());
        ref_mem[5] = merge(ref_mem[5], 16'hABCD, 2'b01);
        check(32'(q_a), 32'(ref_mem[5]));
        wb(1'b1, dprc_pkg::REG_CTRL, 32'h0232);
        op(mk(9'h005, 16'h1234, 1'b1, 1'b1, 2'b11), idle());
        check(32'(q_a), 32'(ref_mem[5]));
        ref_mem[5] = 16'h1234;
        op(mk(9'h007, 16'h5555, 1'b1, 1'b0, 2'b11), mk(9'h007, 16'h0, 1'b0, 1'b1, 2'b00));
        check(32'(q_b), 32'(ref_mem[7]));
        check(32'(q_a), 32'h00CD);
        ref_mem[7] = 16'h5555;
        ce <= 4'hE;
        op(mk(9'h007, 16'h0, 1'b0, 1'b1, 2'b00), idle());
        check(32'(q_a), 32'h00CD);
        wb(1'b1, dprc_pkg::REG_CTRL, 32'h0202);
        ce <= 4'hB;
        op(mk(9'h007, 16'h0, 1'b0, 1'b1, 2'b00), mk(9'h007, 16'h0, 1'b0, 1'b1, 2'b00));
        check(32'(q_a), 32'(ref_mem[7]));
        check(32'(q_b), 32'h0007);
        ce <= 4'hF;
        wb(1'b1, dprc_pkg::REG_CTRL, 32'h0021);
        op(mk(9'h009, 16'h9999, 1'b1, 1'b0, 2'b11), mk(9'h009, 16'h0, 1'b0, 1'b1, 2'b00));
        check(32'(q_b), 32'hFFFF);
        ref_mem[9] = 16'h9999;
        ce <= 4'hB;
        op(idle(), mk(9'h009, 16'h0, 1'b0, 1'b1, 2'b00));
        check(32'(q_b), 32'hFFFF);
        ce <= 4'hF;
        wb(1'b0, dprc_pkg::REG_STAT, 32'h0);
        check(rd, 32'h2);
        wb(1'b1, dprc_pkg::REG_STAT, 32'h2);
        wb(1'b0, dprc_pkg::REG_STAT, 32'h0);
        check(rd, 32'h0);
        wb(1'b1, dprc_pkg::REG_CTRL, 32'h0022);
        wb(1'b0, dprc_pkg::REG_STAT, 32'h0);
        check(rd, 32'h1);
        op(mk(9'h00B, 16'hEEEE, 1'b1, 1'b0, 2'b11), idle());
        wb(1'b1, dprc_pkg::REG_CTRL, 32'h1232);
        op(mk(9'h00B, 16'h0, 1'b0, 1'b1, 2'b00), idle());
        check(32'(q_a), 32'(ref_mem[7]));
        @(posedge ref_clk_in);
        #1;
        check(32'(q_a), 32'(ref_mem[11]));
        wb(1'b1, dprc_pkg::REG_CTRL, 32'h1212);
        ce <= 4'hD;
        op(mk(9'h009, 16'h0, 1'b0, 1'b1, 2'b00), idle());
        @(posedge ref_clk_in);
        #1;
        check(32'(q_a), 32'(ref_mem[11]));
        ce <= 4'hF;
        @(posedge ref_clk_in);
        #1;
        check(32'(q_a), 32'(ref_mem[9]));
        wb(1'b1, dprc_pkg::REG_CTRL, 32'h0232);
        repeat (40) begin
            ad = 9'($random(seed));
            wd = 16'($random(seed));
            be = 2'($random(seed));
            w  = 1'($random(seed));
            op(mk(ad, wd, w, 1'b1, be), idle());
            check(32'(q_a), 32'(ref_mem[ad]));
            if (w) ref_mem[ad] = merge(ref_mem[ad], wd, be);
        end
        complete_run();
    end
endmodule : dprc_ram_tb_top
